// [rolling_shutter_frame_readout_test.sv]
`timescale 1ns/100ps
`default_nettype none
module rolling_shutter_frame_readout_test
  import rsfr_pkg::*;
;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  localparam int NC = 4;
  localparam int NR = 3;
  logic clk = 0, rst_n = 0, oe_n = 0, stream = 0, gmode = 0, cap = 0, hdr = 0;
  logic arb = 0, emb = 0, stat = 0, mh = 0, mv = 0;
  logic [1:0]  ratio = 2'h0, sel = 2'h0;
  logic [10:0] t2 = 11'h001, integ = 11'h001;
  logic [10:0] wc = 11'(NC), wr = 11'(NR);
  logic pclk, fv, lv, boe, shut, grst, rstb, rsec, busy, hact;
  logic [PIX_W-1:0] pd, adata;
  logic [10:0] acol, arow, rrow;
  logic [PIX_W-1:0] key = '0;
  int err_count = 0;
  int num_checks = 0;
  bit rmon = 1'b0;

  // array contents: scrambled address
  function automatic logic [PIX_W-1:0] pix(input int c, input int r);
    return PIX_W'((r * 64 + c) ^ int'(key));
  endfunction
  always_comb adata = pix(int'(acol), int'(arow));

  rsfr_readout #(.HBLANK_WORDS(11'h002), .VBLANK_WORDS(11'h004)) dut_u (
    .i_clk(clk), .i_reset_n(rst_n), .i_output_enable_n(oe_n),
    .o_pixel_out_clock(pclk), .o_frame_valid(fv), .o_line_valid(lv),
    .o_pixel_data(pd), .o_bus_oe(boe), .o_shutter_open(shut), .o_global_reset(grst),
    .i_stream_enable(stream), .i_global_mode(gmode), .i_capture_start(cap),
    .i_hdr_enable(hdr), .i_hdr_ratio(ratio), .i_hdr_arbitrary(arb), .i_t2_rows(t2),
    .i_hdr_out_sel(sel), .i_integ_rows(integ), .i_embed_data_en(emb),
    .i_embed_stats_en(stat), .i_mirror_h(mh), .i_mirror_v(mv), .i_win_cols(wc),
    .i_win_rows(wr), .o_array_col(acol), .o_array_row(arow), .i_array_data(adata),
    .o_reset_strobe(rstb), .o_reset_row(rrow), .o_reset_second(rsec),
    .o_frame_busy(busy), .o_hdr_active(hact));

  rsfr_host host_u (.i_pclk(pclk), .i_fv(fv), .i_lv(lv), .i_oe(boe), .i_data(pd));

  initial begin
    forever #10 clk = ~clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      err_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic wait_frames(input int n);
    int t;
    t = 0;
    while (host_u.frames < n && t < 4000) begin
      @(negedge clk);
      t++;
    end
    chk(host_u.frames >= n, "frame end timeout");
  endtask

  task automatic idle_wait();
    int t;
    t = 0;
    while (busy !== 1'b0 && t < 4000) begin
      @(negedge clk);
      t++;
    end
  endtask

  // reset row model: read row plus exposure rows, modulo the window
  function automatic int rrow_exp();
    int v;
    v = int'(integ) >> (int'(ratio) + int'(RATIO_BASE));
    v = (v == 0) ? 1 : v;
    if (rsec) v = arb ? int'(t2) : v;
    else v = int'(integ);
    return int'(ROW_ORIGIN) + (int'(arow) - int'(ROW_ORIGIN) + v) % NR;
  endfunction

  always @(negedge clk) begin
    if (rmon && rstb === 1'b1) chk(int'(rrow) == rrow_exp(), "reset row");
  end

  // stream two frames, check the second; rep 0 skips data
  task automatic run(input int nl, input int rep, input int off);
    int k, pc, pr;
    rmon = 1'b1;
    @(negedge clk) stream = 1'b1;
    wait_frames(host_u.frames + 1);
    host_u.words.delete();
    host_u.lens.delete();
    wait_frames(host_u.frames + 1);
    rmon = 1'b0;
    integ = 11'($urandom_range(1, 2));  // new integration mid stream
    chk(host_u.lens.size() == nl, "line count");
    chk(hact === hdr, "hdr state");
    chk(host_u.bad == 0, "line valid outside frame");
    if (rep > 0) begin
      k = off * NC;
      for (int r = 0; r < NR; r++) begin
        for (int p = 0; p < rep; p++) begin
          for (int c = 0; c < NC; c++) begin
            pc = mh ? NC - 1 - c : c;  // mirrored readout runs backwards
            pr = mv ? NR - 1 - r : r;
            chk(host_u.words[k] === pix(10 + pc, 14 + pr), "pixel word");
            k++;
          end
        end
      end
    end
    @(negedge clk) stream = 1'b0;
    idle_wait();
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #1_000_000;
    err_count++;
    end_of_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(45));
    key = PIX_W'($urandom);
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    run(NR, 1, 0);
    emb = 1'b1;
    stat = 1'b1;
    run(NR + 4, 1, 2);
    emb = 1'b0;
    stat = 1'b0;
    hdr = 1'b1;
    integ = 11'h040;  // long enough for the 32x ratio check
    for (int s = 0; s < 3; s++) begin
      sel = 2'(s);
      ratio = (s == 0) ? 2'h3 : 2'($urandom_range(0, 3));
      run(s == 0 ? 2 * NR : NR, s == 0 ? 2 : 1, 0);
    end
    sel = 2'h0;
    arb = 1'b1;
    t2 = 11'($urandom_range(1, 3));
    run(2 * NR, 2, 0);
    hdr = 1'b0;
    arb = 1'b0;
    mh = 1'b1;
    mv = 1'b1;
    run(NR, 1, 0);
    mh = 1'b0;
    mv = 1'b0;
    oe_n = 1'b1;
    repeat (10) @(negedge clk);
    chk(boe === 1'b0, "bus driven while disabled");
    oe_n = 1'b0;
    repeat (10) @(negedge clk);
    chk(boe === 1'b1, "bus not driven while enabled");
    gmode = 1'b1;
    integ = 11'h001;
    host_u.lens.delete();
    cap = 1'b1;
    @(negedge clk) cap = 1'b0;
    repeat (30) @(negedge clk);
    chk(grst === 1'b1 && shut === 1'b0, "array reset not held");
    repeat (170) @(negedge clk);
    chk(shut === 1'b1 && grst === 1'b0, "shutter not open");
    wait_frames(host_u.frames + 1);
    chk(host_u.lens.size() == NR, "capture line count");
    idle_wait();
    chk(shut === 1'b0 && busy === 1'b0, "capture not ended");
    gmode = 1'b0;
    stream = 1'b1;
    repeat (150) @(negedge clk);
    rst_n = 1'b0;
    #1;
    chk(fv === 1'b0 && lv === 1'b0 && boe === 1'b0 && arow === ROW_ORIGIN, "reset");
    chk(busy === 1'b0 && hact === 1'b0 && rstb === 1'b0, "reset state");
    stream = 1'b0;
    @(negedge clk) rst_n = 1'b1;
    end_of_test();
  end
endmodule
`default_nettype wire

// [rsfr_buf2.sv]
`timescale 1ns/100ps
`default_nettype none
module rsfr_buf2 #(
  parameter int W = 14
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  // fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  logic [W-1:0] mem_ff [2];
  logic         wr_ff;
  logic         rd_ff;
  logic [1:0]   cnt_ff;
  wire          push = i_in_valid && o_in_ready;
  wire          pop  = o_out_valid && i_out_ready;

  // honest full and empty
  assign o_in_ready  = (cnt_ff != 2'h2);
  assign o_out_valid = (cnt_ff != 2'h0);
  assign o_out_data  = mem_ff[rd_ff];

  // storage
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= i_in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ff  <= 1'b0;
      rd_ff  <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      wr_ff  <= wr_ff ^ push;
      rd_ff  <= rd_ff ^ pop;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// [rsfr_host.sv]
`timescale 1ns/100ps
`default_nettype none
module rsfr_host
  import rsfr_pkg::*;
(
  // parallel bus from the sensor
  input wire logic             i_pclk,
  input wire logic             i_fv,
  input wire logic             i_lv,
  input wire logic             i_oe,
  input wire logic [PIX_W-1:0] i_data
);
  // ------------------------------------------------------------
  // capture state
  // ------------------------------------------------------------
  logic [PIX_W-1:0] words[$];
  int               lens[$];
  int               cur    = 0;
  int               frames = 0;
  int               bad    = 0;
  logic             fv_d   = 1'b0;
  logic             lv_d   = 1'b0;

  // sample only on rising pixel clock, ignore an undriven bus
  always @(posedge i_pclk) begin
    if (i_oe) begin
      if (i_fv && i_lv) begin
        words.push_back(i_data);
        cur++;
      end
      if (i_lv && !i_fv) bad++;  // line data outside a frame
      if (lv_d && !i_lv) begin
        lens.push_back(cur);
        cur = 0;
      end
      if (fv_d && !i_fv) frames++;
      fv_d = i_fv;
      lv_d = i_lv;
    end
  end
endmodule
`default_nettype wire

// [rsfr_pkg.sv]
package rsfr_pkg;
  // ------------------------------------------------------------
  // geometry and widths
  // ------------------------------------------------------------
  localparam int             PIX_W      = 12;
  localparam int             ADR_W      = 11;
  localparam int             WORD_W     = PIX_W + 2;
  localparam logic [10:0]    MAX_COLS   = 11'h788;  // 1928 columns
  localparam logic [10:0]    MAX_ROWS   = 11'h440;  // 1088 rows
  localparam logic [10:0]    COL_ORIGIN = 11'h00a;  // first column read
  localparam logic [10:0]    ROW_ORIGIN = 11'h00e;  // first row read
  localparam logic [10:0]    EMB_ROWS   = 11'h002;
  localparam logic [10:0]    STAT_ROWS  = 11'h002;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int             CLK_MHZ         = 50;
  localparam int             PIXEL_OUT_CLOCK_PERIOD_NS = 160;
  localparam logic [3:0]     PIX_HALF   = 4'(PIXEL_OUT_CLOCK_PERIOD_NS * CLK_MHZ / 2000);
  localparam int             SHUT_SHIFT = 8;        // clock cycles per row, log2
  localparam logic [19:0]    GR_RESET_CYC  = 20'h00040;
  localparam logic [19:0]    SHUT_CLOSE_CYC = 20'h00100;

  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  localparam logic [1:0]     K_EMB  = 2'h0;
  localparam logic [1:0]     K_ACT  = 2'h1;
  localparam logic [1:0]     K_STAT = 2'h2;
  localparam logic [1:0]     OUT_BOTH   = 2'h0;
  localparam logic [1:0]     OUT_FIRST  = 2'h1;
  localparam logic [1:0]     OUT_SECOND = 2'h2;
  localparam logic [3:0]     RATIO_BASE = 4'h2;     // code 0 means 4x

  typedef enum logic [2:0] {
    ST_IDLE, ST_GR_RESET, ST_GR_EXPOSE, ST_GR_CLOSE,
    ST_ROWS, ST_HBLANK, ST_VBLANK
  } rsfr_state_e;
endpackage

// [rsfr_readout.sv]
`timescale 1ns/100ps
`default_nettype none
module rsfr_readout
  import rsfr_pkg::*;
#(
  parameter logic [10:0] HBLANK_WORDS = 11'h010,
  parameter logic [10:0] VBLANK_WORDS = 11'h020
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  // parallel output pins
  input  wire logic             i_output_enable_n,
  output logic                  o_pixel_out_clock,
  output logic                  o_frame_valid,
  output logic                  o_line_valid,
  output logic [PIX_W-1:0]      o_pixel_data,
  output logic                  o_bus_oe,
  output logic                  o_shutter_open,
  output logic                  o_global_reset,
  // configuration
  input  wire logic             i_stream_enable,
  input  wire logic             i_global_mode,
  input  wire logic             i_capture_start,
  input  wire logic             i_hdr_enable,
  input  wire logic [1:0]       i_hdr_ratio,
  input  wire logic             i_hdr_arbitrary,
  input  wire logic [ADR_W-1:0] i_t2_rows,
  input  wire logic [1:0]       i_hdr_out_sel,
  input  wire logic [ADR_W-1:0] i_integ_rows,
  input  wire logic             i_embed_data_en,
  input  wire logic             i_embed_stats_en,
  input  wire logic             i_mirror_h,
  input  wire logic             i_mirror_v,
  input  wire logic [ADR_W-1:0] i_win_cols,
  input  wire logic [ADR_W-1:0] i_win_rows,
  // pixel array
  output logic [ADR_W-1:0]      o_array_col,
  output logic [ADR_W-1:0]      o_array_row,
  input  wire logic [PIX_W-1:0] i_array_data,
  output logic                  o_reset_strobe,
  output logic [ADR_W-1:0]      o_reset_row,
  output logic                  o_reset_second,
  // status
  output logic                  o_frame_busy,
  output logic                  o_hdr_active
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [10:0] clamp(input logic [10:0] v, input logic [10:0] mx);
    clamp = (v == 11'h000) ? 11'h001 : ((v > mx) ? mx : v);
  endfunction

  function automatic logic [10:0] wrap(input logic [10:0] a, input logic [10:0] b,
                                       input logic [10:0] n);
    logic [11:0] s;
    s = ({1'b0, a} + {1'b0, b}) % {1'b0, n};  // offset may exceed the window
    wrap = s[10:0];
  endfunction

  rsfr_state_e      state_ff;
  rsfr_state_e      nxt_state;
  logic [3:0]       half_ff;
  logic             ph_ff;
  logic [19:0]      cnt_ff;
  logic [10:0]      col_ff;
  logic [10:0]      line_ff;
  logic [10:0]      blank_ff;
  logic [1:0]       kind_ff;
  logic             exp_ff;
  logic             gr_ff;
  logic [10:0]      cols_ff;
  logic [10:0]      rows_ff;
  logic [10:0]      integ_ff;
  logic [10:0]      t2_ff;
  logic             hdr_ff;
  logic [1:0]       sel_ff;
  logic             emb_ff;
  logic             stat_ff;
  logic             mir_h_ff;
  logic             mir_v_ff;
  logic [11:0]      frame_cnt_ff;
  logic [23:0]      sum_ff;
  logic             oe_n_q;
  logic             in_ready;
  logic             out_valid;
  logic [WORD_W-1:0] out_word;

  // ------------------------------------------------------------
  // pixel clock divider and output enable
  // ------------------------------------------------------------
  wire half_tick = (half_ff == PIX_HALF - 4'h1);
  wire fall_en   = half_tick && o_pixel_out_clock;

  rsfr_sync3 #(.RST_VAL(1'b1)) u_oe_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_output_enable_n),
    .o_level   (oe_n_q)
  );

  // divide the core clock into the pixel clock, oe follows the pin
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      half_ff           <= 4'h0;
      o_pixel_out_clock <= 1'b0;
      o_bus_oe          <= 1'b0;
    end else begin
      half_ff           <= half_tick ? 4'h0 : half_ff + 4'h1;
      o_pixel_out_clock <= o_pixel_out_clock ^ half_tick;
      o_bus_oe          <= !oe_n_q;
    end
  end

  // ------------------------------------------------------------
  // line sequencing decode
  // ------------------------------------------------------------
  wire in_stream  = (state_ff == ST_ROWS) || (state_ff == ST_HBLANK) ||
                    (state_ff == ST_VBLANK);
  wire push       = in_stream && ph_ff && in_ready;
  wire last_col   = (col_ff == cols_ff - 11'h001);
  wire hb_done    = push && (state_ff == ST_HBLANK) && (blank_ff == HBLANK_WORDS);
  wire vb_done    = push && (state_ff == ST_VBLANK) && (blank_ff == VBLANK_WORDS);
  wire act_last   = (line_ff == rows_ff - 11'h001);
  wire emb_last   = (line_ff == EMB_ROWS - 11'h001);
  wire stat_last  = (line_ff == STAT_ROWS - 11'h001);
  wire two_lines  = hdr_ff && !exp_ff && (kind_ff == K_ACT);
  wire frame_end  = (kind_ff == K_STAT && stat_last) ||
                    (kind_ff == K_ACT && !two_lines && act_last && !stat_ff);
  wire gr_go      = (state_ff == ST_IDLE) && i_global_mode && i_capture_start;
  wire rs_go      = i_stream_enable && !i_global_mode;
  wire start_frame = ((state_ff == ST_IDLE) && rs_go) ||
                     (vb_done && rs_go && !gr_ff) ||
                     ((state_ff == ST_GR_CLOSE) && (cnt_ff == SHUT_CLOSE_CYC));
  wire [10:0] integ_new = clamp(i_integ_rows, MAX_ROWS);
  wire [10:0] t2_auto = integ_new >> (RATIO_BASE + {2'h0, i_hdr_ratio});
  wire [10:0] t2_pick = i_hdr_arbitrary ? i_t2_rows : t2_auto;
  wire shown      = (kind_ff != K_ACT) || !hdr_ff || (sel_ff == OUT_BOTH) ||
                    ((sel_ff == OUT_FIRST) && !exp_ff) ||
                    ((sel_ff == OUT_SECOND) && exp_ff);
  wire [10:0] col_m = mir_h_ff ? cols_ff - 11'h001 - col_ff : col_ff;
  wire [10:0] row_m = mir_v_ff ? rows_ff - 11'h001 - line_ff : line_ff;
  wire [PIX_W-1:0] word_px = (kind_ff == K_ACT) ? i_array_data :
                             (kind_ff == K_EMB) ?
                             ((col_ff == 11'h000) ? frame_cnt_ff : {1'b0, integ_ff}) :
                             sum_ff[23:12];
  wire row_word   = (state_ff == ST_ROWS);
  wire [WORD_W-1:0] in_word = {state_ff != ST_VBLANK, row_word && shown,
                               row_word ? word_px : {PIX_W{1'b0}}};

  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (gr_go) begin
          nxt_state = ST_GR_RESET;
        end else if (start_frame) begin
          nxt_state = ST_ROWS;
        end
      end
      ST_GR_RESET: begin
        if (cnt_ff == GR_RESET_CYC) begin
          nxt_state = ST_GR_EXPOSE;
        end
      end
      ST_GR_EXPOSE: begin
        if (cnt_ff == {1'b0, integ_ff, SHUT_SHIFT'(0)}) begin
          nxt_state = ST_GR_CLOSE;
        end
      end
      ST_GR_CLOSE: begin
        if (start_frame) begin
          nxt_state = ST_ROWS;
        end
      end
      ST_ROWS: begin
        if (push && last_col) begin
          nxt_state = ST_HBLANK;
        end
      end
      ST_HBLANK: begin
        if (hb_done) begin
          nxt_state = frame_end ? ST_VBLANK : ST_ROWS;
        end
      end
      ST_VBLANK: begin
        if (start_frame) begin
          nxt_state = ST_ROWS;
        end else if (vb_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // state, phase and cycle counter
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= ST_IDLE;
      ph_ff    <= 1'b0;
      cnt_ff   <= 20'h00000;
    end else begin
      state_ff <= nxt_state;
      ph_ff    <= in_stream && !push;
      cnt_ff   <= (nxt_state != state_ff) ? 20'h00000 : cnt_ff + 20'h00001;
    end
  end

  // settings are taken only at frame or capture start
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {cols_ff, rows_ff} <= {MAX_COLS, MAX_ROWS};
      {integ_ff, t2_ff}  <= {11'h001, 11'h001};
      {hdr_ff, sel_ff, emb_ff, stat_ff, mir_h_ff, mir_v_ff} <= 7'h00;
    end else if (start_frame || gr_go) begin
      cols_ff  <= clamp(i_win_cols, MAX_COLS);
      rows_ff  <= clamp(i_win_rows, MAX_ROWS);
      integ_ff <= clamp(i_integ_rows, MAX_ROWS);
      t2_ff    <= clamp(t2_pick, MAX_ROWS);
      hdr_ff   <= i_hdr_enable;
      sel_ff   <= i_hdr_out_sel;
      emb_ff   <= i_embed_data_en;
      stat_ff  <= i_embed_stats_en;
      mir_h_ff <= i_mirror_h;
      mir_v_ff <= i_mirror_v;
    end
  end

  // column, line, exposure and blanking counters
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {col_ff, line_ff, blank_ff} <= {3{11'h000}};
      kind_ff <= K_ACT;
      exp_ff  <= 1'b0;
      gr_ff   <= 1'b0;
    end else if (start_frame) begin
      {col_ff, line_ff, blank_ff} <= {3{11'h000}};
      kind_ff <= i_embed_data_en ? K_EMB : K_ACT;
      exp_ff  <= 1'b0;
      gr_ff   <= (state_ff == ST_GR_CLOSE);
    end else if (push) begin
      col_ff   <= (row_word && !last_col) ? col_ff + 11'h001 : 11'h000;
      blank_ff <= (row_word || hb_done) ? 11'h000 : blank_ff + 11'h001;
      if (hb_done && !frame_end) begin
        exp_ff  <= two_lines;
        line_ff <= ((kind_ff == K_ACT && two_lines) || (kind_ff == K_EMB && !emb_last) ||
                    (kind_ff == K_ACT && !act_last) || kind_ff == K_STAT) ?
                   (two_lines ? line_ff : line_ff + 11'h001) : 11'h000;
        if (kind_ff == K_EMB && emb_last) begin
          kind_ff <= K_ACT;
        end else if (kind_ff == K_ACT && !two_lines && act_last) begin
          kind_ff <= K_STAT;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // array addressing, row resets, statistics
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_array_col    <= COL_ORIGIN;
      o_array_row    <= ROW_ORIGIN;
      o_reset_strobe <= 1'b0;
      o_reset_row    <= ROW_ORIGIN;
      o_reset_second <= 1'b0;
    end else begin
      o_array_col    <= COL_ORIGIN + col_m;
      o_array_row    <= ROW_ORIGIN + row_m;
      o_reset_strobe <= push && row_word && (kind_ff == K_ACT) && (col_ff == 11'h000);
      o_reset_row    <= ROW_ORIGIN +
                        wrap(row_m, exp_ff ? t2_ff : integ_ff, rows_ff);
      o_reset_second <= exp_ff;
    end
  end

  // frame count for the embedded rows, pixel sum for the statistics rows
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      frame_cnt_ff <= 12'h000;
      sum_ff       <= 24'h000000;
    end else if (start_frame) begin
      frame_cnt_ff <= frame_cnt_ff + 12'h001;
      sum_ff       <= 24'h000000;
    end else if (push && row_word && kind_ff == K_ACT) begin
      sum_ff <= sum_ff + {12'h000, i_array_data};
    end
  end

  // shutter control, status
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {o_shutter_open, o_global_reset, o_frame_busy, o_hdr_active} <= 4'h0;
    end else begin
      o_global_reset <= (nxt_state == ST_GR_RESET);
      o_shutter_open <= (nxt_state == ST_GR_EXPOSE);
      o_frame_busy   <= (nxt_state != ST_IDLE);
      o_hdr_active   <= hdr_ff;
    end
  end

  // ------------------------------------------------------------
  // word buffer and output stage
  // ------------------------------------------------------------
  rsfr_buf2 #(.W(WORD_W)) u_buf (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (in_stream && ph_ff),
    .i_in_data   (in_word),
    .o_in_ready  (in_ready),
    .o_out_valid (out_valid),
    .o_out_data  (out_word),
    .i_out_ready (fall_en)
  );

  // new word on the falling pixel clock edge, stable at the rising one
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {o_frame_valid, o_line_valid, o_pixel_data} <= {WORD_W{1'b0}};
    end else if (fall_en) begin
      if (out_valid) begin
        {o_frame_valid, o_line_valid, o_pixel_data} <= out_word;
      end else begin
        o_line_valid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  AST_LV_IN_FV: assert property (o_line_valid |-> o_frame_valid)
    else $error("line valid outside frame valid");
  AST_DATA_AT_RISE: assert property ($rose(o_pixel_out_clock) |-> $stable(o_pixel_data))
    else $error("pixel data moved at pixel clock rise");
  AST_OE: assert property (oe_n_q ##1 oe_n_q |-> !o_bus_oe)
    else $error("bus driven while output enable high");
  AST_LINEAR: assert property (start_frame && !i_hdr_enable |=> !hdr_ff)
    else $error("hdr entered without selection");
  AST_INTEG_HOLD: assert property (!start_frame && !gr_go |=> $stable(integ_ff) && $stable(t2_ff))
    else $error("integration changed inside a frame");
  AST_FIRST_PIXEL: assert property (ph_ff && row_word && col_ff == 11'h000 &&
      line_ff == 11'h000 && !mir_h_ff && !mir_v_ff && $stable(col_ff) |->
      o_array_col == COL_ORIGIN && o_array_row == ROW_ORIGIN)
    else $error("first pixel not at origin");
  AST_ROW_DONE: assert property (push && row_word && last_col |=> state_ff == ST_HBLANK)
    else $error("row not finished before blanking");
  AST_WINDOW: assert property (cols_ff <= MAX_COLS && rows_ff <= MAX_ROWS)
    else $error("window beyond array");
  AST_SHUTTER: assert property (state_ff == ST_GR_EXPOSE [*2] |-> o_shutter_open)
    else $error("shutter closed during exposure");
  AST_RATIO: assert property (start_frame && i_hdr_enable && !i_hdr_arbitrary &&
      i_hdr_ratio == 2'h3 && i_integ_rows >= 11'h040 && i_integ_rows <= MAX_ROWS |=>
      t2_ff == (integ_ff >> 5))
    else $error("32x ratio wrong");
  AST_HB_LOW: assert property (push && state_ff == ST_HBLANK |->
      in_word[WORD_W-1] && !in_word[WORD_W-2])
    else $error("line valid high in line blanking");
  AST_VB_LOW: assert property (push && state_ff == ST_VBLANK |->
      !in_word[WORD_W-1] && !in_word[WORD_W-2])
    else $error("frame valid high in frame blanking");
endmodule
`default_nettype wire

// [rsfr_sync3.sv]
`timescale 1ns/100ps
`default_nettype none
module rsfr_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // pin and clean level
  input  wire logic i_pin,
  output logic      o_level
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // three stages, level moves once stages two and three agree
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_ff   <= RST_VAL;
      s2_ff   <= RST_VAL;
      s3_ff   <= RST_VAL;
      o_level <= RST_VAL;
    end else begin
      s1_ff <= i_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        o_level <= s3_ff;
      end
    end
  end
endmodule
`default_nettype wire
